// file: hdl/hpt_pkg.sv
// Package with register map, field layout, timing and state types.
package hpt_pkg;
  // Register byte offsets on the host register port.
  localparam logic [7:0] SLOT_FIRST_ADDR  = 8'h04;
  localparam logic [7:0] SLOT_LAST_ADDR   = 8'h0B;
  localparam logic [7:0] TRIG_ADDR        = 8'h0C;
  localparam logic [7:0] OD_OFFSET_ADDR   = 8'h0D;
  localparam logic [7:0] SP_OFFSET_ADDR   = 8'h0E;
  localparam logic [7:0] SN_OFFSET_ADDR   = 8'h0F;
  // Reset values and field positions.
  localparam logic [7:0] REG_RESET        = 8'h00;
  localparam int         TRIG_BIT         = 0;
  localparam int         SLOT_DELAY_BIT   = 7;
  localparam int         SLOT_COUNT       = 8;
  localparam logic [2:0] SLOT_LAST_IDX    = 3'h7;
  // Operating-mode codes that redirect the trigger.
  localparam logic [2:0] MODE_DIAG        = 3'h6;
  localparam logic [2:0] MODE_CAL         = 3'h7;
  // Waveform library layout: four segments of amplitude and duration.
  localparam int         LIB_AW           = 9;
  localparam int         LIB_DW           = 16;
  localparam logic [1:0] SEG_LAST_IDX     = 2'h3;
  localparam logic [7:0] AMP_MOST_NEG     = 8'h80;
  localparam logic [7:0] DUR_END          = 8'h00;
  // Timing: offsets count in 5 ms steps, delay slots in 10 ms steps.
  localparam int         STEP_TIME_MS     = 5;
  localparam int         WAIT_TIME_MS     = 10;
  localparam int         CLK_FREQ_KHZ     = 40000;
  localparam int         STEP_CYCLES_DEF  = STEP_TIME_MS * CLK_FREQ_KHZ;
  localparam int         WAIT_STEPS       = WAIT_TIME_MS / STEP_TIME_MS;
  localparam int         TICK_W           = 18;
  localparam int         DUR_W            = 10;
  localparam logic [DUR_W-1:0] DUR_ZERO   = 10'h000;
  localparam logic [DUR_W-1:0] DUR_ONE    = 10'h001;
  localparam logic [TICK_W-1:0] TICK_ZERO = 18'h0_0000;
  localparam logic [TICK_W-1:0] TICK_ONE  = 18'h0_0001;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SLOT, ST_SCAN_RD, ST_SCAN_CHK, ST_SEG_RD,
    ST_SEG_CHK, ST_PLAY, ST_WAIT, ST_EXT
  } hpt_state_t;
endpackage

// file: hdl/hpt_lib_if.sv
// Interface between the playback engine and the waveform library.
`timescale 1ns/1ps
interface hpt_lib_if;
  logic [8:0]  addr;
  logic        en;
  logic [15:0] data;
  modport ctrl (output addr, output en, input data);
  modport mem  (input addr, input en, output data);
endinterface

// file: hdl/hpt_wave_lib.sv
// Waveform library memory with a registered read port.
`timescale 1ns/1ps
module hpt_wave_lib
  import hpt_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  hpt_lib_if.mem   lib
);
  logic [LIB_DW-1:0] data_q;
  logic [LIB_DW-1:0] data_d;

  // Fixed contents: overdrive burst, positive sustain, negative brake.
  function automatic logic [LIB_DW-1:0] libWord(input logic [LIB_AW-1:0] a);
    logic [6:0] id;
    logic [1:0] seg;
    id  = a[LIB_AW-1:2];
    seg = a[1:0];
    if (id == 7'h00) begin
      libWord = 16'h0000;
    end else begin
      unique case (seg)
        2'h0: libWord = 16'h7F04;
        2'h1: libWord = {8'h40, 4'h0, id[3:0]};
        2'h2: libWord = 16'hC002;
        2'h3: libWord = 16'h0000;
      endcase
    end
  endfunction

  // Read data comes only from the register, one cycle after en.
  always_comb begin
    data_d = data_q;
    if (lib.en) begin
      data_d = libWord(lib.addr);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      data_q <= 16'h0000;
    end else if (ce) begin
      data_q <= data_d;
    end
  end

  assign lib.data = data_q;
endmodule

// file: hdl/hpt_trigger.sv
// Playback trigger register bank with sequencer and time offsets.
`timescale 1ns/1ps
// Functional notes
// - Trigger bit starts process chosen by mode.
// - Trigger plays waveform ids from sequence slots.
// - Trigger reads one until sequence completes.
// - Clearing trigger aborts playing sequence immediately.
// - Mode may launch calibration or diagnostics instead.
// - Signed overdrive offset, 5 ms per count.
// - Overdrive is segment with maximum drive value.
// - Overdrive offset ignored in closed loop.
// - Signed positive sustain offset, 5 ms per count.
// - Other positive drive values are positive sustain.
// - Signed negative sustain offset, 5 ms per count.
// - Other negative drive values are negative sustain.
// - Slots play in order, stop at zero or eight.
// - Delay slot idles ten ms times value.
module hpt_trigger
  import hpt_pkg::*;
#(
  parameter int STEP_CYCLES = STEP_CYCLES_DEF
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  input  wire logic [2:0] modeSel,
  input  wire logic       openLoop,
  input  wire logic       calDone,
  input  wire logic       diagDone,
  output logic            calStart,
  output logic            diagStart,
  output logic      [7:0] driveLevel,
  output logic            driveOn
);
  localparam logic [TICK_W-1:0] STEP_LAST = TICK_W'(STEP_CYCLES - 1);

  hpt_lib_if lib ();

  hpt_wave_lib u_lib (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .lib     (lib.mem)
  );

  logic [7:0]        slot_q [SLOT_COUNT];
  logic [7:0]        slot_d [SLOT_COUNT];
  logic [7:0]        odOff_q, odOff_d;
  logic [7:0]        spOff_q, spOff_d;
  logic [7:0]        snOff_q, snOff_d;
  logic              go_q, go_d;
  logic [7:0]        rd_q, rd_d;
  hpt_state_t        st_q, st_d;
  logic [2:0]        slotIdx_q, slotIdx_d;
  logic [1:0]        segIdx_q, segIdx_d;
  logic [1:0]        odIdx_q, odIdx_d;
  logic [7:0]        maxAmp_q, maxAmp_d;
  logic [DUR_W-1:0]  durLeft_q, durLeft_d;
  logic [TICK_W-1:0] tick_q, tick_d;
  logic [7:0]        drive_q, drive_d;
  logic              driveOn_q, driveOn_d;
  logic              cal_q, cal_d;
  logic              diag_q, diag_d;
  logic [7:0]        curSlot;
  logic [7:0]        libAmp;
  logic [7:0]        libDur;
  logic [7:0]        segOff;
  logic [DUR_W-1:0]  adjSum;
  logic [DUR_W-1:0]  adjDur;
  logic              tickHit;
  logic              trigWr;
  logic              segAdvance;

  // Slot address decode, shared by the write and read paths.
  function automatic logic isSlot(input logic [7:0] a);
    isSlot = (a >= SLOT_FIRST_ADDR) && (a <= SLOT_LAST_ADDR);
  endfunction

  function automatic logic [2:0] slotOf(input logic [7:0] a);
    logic [7:0] d;
    d = a - SLOT_FIRST_ADDR;
    slotOf = d[2:0];
  endfunction

  assign curSlot = slot_q[slotIdx_q];
  assign libAmp  = lib.data[15:8];
  assign libDur  = lib.data[7:0];
  assign tickHit = (tick_q == STEP_LAST);
  assign trigWr  = regWrEn && (regAddr == TRIG_ADDR);

  // Pick the offset for this segment by its class.
  always_comb begin
    segOff = 8'h00;
    if (segIdx_q == odIdx_q && libAmp == maxAmp_q) begin
      segOff = openLoop ? odOff_q : 8'h00;
    end else if (!libAmp[7] && libAmp != 8'h00) begin
      segOff = spOff_q;
    end else if (libAmp[7]) begin
      segOff = snOff_q;
    end
  end

  // Signed adjust; a negative result clamps so nothing wraps.
  assign adjSum = {2'b00, libDur} + {{2{segOff[7]}}, segOff};
  assign adjDur = adjSum[DUR_W-1] ? DUR_ZERO : adjSum;
  assign segAdvance = (segIdx_q == SEG_LAST_IDX);

  // Register writes and the read path.
  always_comb begin
    slot_d  = slot_q;
    odOff_d = odOff_q;
    spOff_d = spOff_q;
    snOff_d = snOff_q;
    rd_d    = rd_q;
    if (regWrEn) begin
      if (isSlot(regAddr)) begin
        slot_d[slotOf(regAddr)] = regWrData;
      end
      if (regAddr == OD_OFFSET_ADDR) odOff_d = regWrData;
      if (regAddr == SP_OFFSET_ADDR) spOff_d = regWrData;
      if (regAddr == SN_OFFSET_ADDR) snOff_d = regWrData;
    end
    if (regRdEn) begin
      if (isSlot(regAddr)) begin
        rd_d = slot_q[slotOf(regAddr)];
      end else begin
        unique case (regAddr)
          TRIG_ADDR:      rd_d = {7'h00, go_q};
          OD_OFFSET_ADDR: rd_d = odOff_q;
          SP_OFFSET_ADDR: rd_d = spOff_q;
          SN_OFFSET_ADDR: rd_d = snOff_q;
          default:        rd_d = 8'h00;
        endcase
      end
    end
  end

  // Playback engine next state.
  always_comb begin
    st_d      = st_q;
    go_d      = go_q;
    slotIdx_d = slotIdx_q;
    segIdx_d  = segIdx_q;
    odIdx_d   = odIdx_q;
    maxAmp_d  = maxAmp_q;
    durLeft_d = durLeft_q;
    tick_d    = tickHit ? TICK_ZERO : tick_q + TICK_ONE;
    drive_d   = drive_q;
    driveOn_d = driveOn_q;
    cal_d     = 1'b0;
    diag_d    = 1'b0;
    lib.en    = 1'b0;
    lib.addr  = {curSlot[6:0], segIdx_q};
    unique case (st_q)
      ST_IDLE: begin
        if (trigWr && regWrData[TRIG_BIT]) begin
          go_d = 1'b1;
          if (modeSel == MODE_CAL) begin
            cal_d = 1'b1;
            st_d  = ST_EXT;
          end else if (modeSel == MODE_DIAG) begin
            diag_d = 1'b1;
            st_d   = ST_EXT;
          end else begin
            slotIdx_d = 3'h0;
            st_d      = ST_SLOT;
          end
        end
      end
      ST_SLOT: begin
        driveOn_d = 1'b0;
        if (curSlot == 8'h00) begin
          go_d = 1'b0;
          st_d = ST_IDLE;
        end else if (curSlot[SLOT_DELAY_BIT]) begin
          durLeft_d = DUR_W'(curSlot[6:0] * WAIT_STEPS);
          tick_d    = TICK_ZERO;
          st_d      = ST_WAIT;
        end else begin
          segIdx_d = 2'h0;
          odIdx_d  = 2'h0;
          maxAmp_d = AMP_MOST_NEG;
          st_d     = ST_SCAN_RD;
        end
      end
      ST_SCAN_RD: begin
        lib.en = 1'b1;
        st_d   = ST_SCAN_CHK;
      end
      ST_SCAN_CHK: begin
        if (libDur != DUR_END && $signed(libAmp) > $signed(maxAmp_q)) begin
          maxAmp_d = libAmp;
          odIdx_d  = segIdx_q;
        end
        if (libDur == DUR_END || segAdvance) begin
          segIdx_d = 2'h0;
          st_d     = ST_SEG_RD;
        end else begin
          segIdx_d = segIdx_q + 2'h1;
          st_d     = ST_SCAN_RD;
        end
      end
      ST_SEG_RD: begin
        lib.en = 1'b1;
        st_d   = ST_SEG_CHK;
      end
      ST_SEG_CHK: begin
        tick_d = TICK_ZERO;
        if (libDur == DUR_END) begin
          st_d = ST_WAIT;
          durLeft_d = DUR_ZERO;
        end else if (adjDur == DUR_ZERO) begin
          st_d     = segAdvance ? ST_WAIT : ST_SEG_RD;
          segIdx_d = segIdx_q + 2'h1;
          durLeft_d = DUR_ZERO;
        end else begin
          durLeft_d = adjDur;
          drive_d   = libAmp;
          driveOn_d = 1'b1;
          st_d      = ST_PLAY;
        end
      end
      ST_PLAY: begin
        if (tickHit) begin
          durLeft_d = durLeft_q - DUR_ONE;
          if (durLeft_q == DUR_ONE) begin
            driveOn_d = 1'b0;
            segIdx_d  = segIdx_q + 2'h1;
            st_d      = segAdvance ? ST_WAIT : ST_SEG_RD;
            durLeft_d = DUR_ZERO;
          end
        end
      end
      ST_WAIT: begin
        driveOn_d = 1'b0;
        if (durLeft_q == DUR_ZERO || (tickHit && durLeft_q == DUR_ONE)) begin
          if (slotIdx_q == SLOT_LAST_IDX) begin
            go_d = 1'b0;
            st_d = ST_IDLE;
          end else begin
            slotIdx_d = slotIdx_q + 3'h1;
            st_d      = ST_SLOT;
          end
        end else if (tickHit) begin
          durLeft_d = durLeft_q - DUR_ONE;
        end
      end
      ST_EXT: begin
        // The routine owns the trigger until it reports completion.
        if (calDone || diagDone) begin
          go_d = 1'b0;
          st_d = ST_IDLE;
        end
      end
    endcase
    // A cleared trigger cancels playback at once, whatever the step.
    if (st_q != ST_IDLE && st_q != ST_EXT && trigWr &&
        !regWrData[TRIG_BIT]) begin
      go_d      = 1'b0;
      driveOn_d = 1'b0;
      st_d      = ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < SLOT_COUNT; i++) begin
        slot_q[i] <= REG_RESET;
      end
      odOff_q   <= REG_RESET;
      spOff_q   <= REG_RESET;
      snOff_q   <= REG_RESET;
      go_q      <= 1'b0;
      rd_q      <= REG_RESET;
      st_q      <= ST_IDLE;
      slotIdx_q <= 3'h0;
      segIdx_q  <= 2'h0;
      odIdx_q   <= 2'h0;
      maxAmp_q  <= AMP_MOST_NEG;
      durLeft_q <= DUR_ZERO;
      tick_q    <= TICK_ZERO;
      drive_q   <= 8'h00;
      driveOn_q <= 1'b0;
      cal_q     <= 1'b0;
      diag_q    <= 1'b0;
    end else if (ce) begin
      slot_q    <= slot_d;
      odOff_q   <= odOff_d;
      spOff_q   <= spOff_d;
      snOff_q   <= snOff_d;
      go_q      <= go_d;
      rd_q      <= rd_d;
      st_q      <= st_d;
      slotIdx_q <= slotIdx_d;
      segIdx_q  <= segIdx_d;
      odIdx_q   <= odIdx_d;
      maxAmp_q  <= maxAmp_d;
      durLeft_q <= durLeft_d;
      tick_q    <= tick_d;
      drive_q   <= drive_d;
      driveOn_q <= driveOn_d;
      cal_q     <= cal_d;
      diag_q    <= diag_d;
    end
  end

  assign regRdData  = rd_q;
  assign calStart   = cal_q;
  assign diagStart  = diag_q;
  assign driveLevel = drive_q;
  assign driveOn    = driveOn_q;
endmodule

// file: sim/hpt_trigger_props.sv
// Checker bound to the trigger register bank ports.
`timescale 1ns/1ps
module hpt_trigger_chk
  import hpt_pkg::*;
#(
  parameter int STEP_CYCLES = STEP_CYCLES_DEF
) (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       ce,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrEn,
  input wire logic       regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic [2:0] modeSel,
  input wire logic       calStart,
  input wire logic       diagStart,
  input wire logic       driveOn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Host strobes to one register, and a write followed by a read of it.
  sequence s_wr(logic [7:0] a);
    ce && regWrEn && regAddr == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    ce && regRdEn && regAddr == a;
  endsequence
  sequence s_wrRd(logic [7:0] a);
    s_wr(a) ##2 s_rd(a);
  endsequence
  // Offsets must return the whole signed byte, no bit dropped.
  property p_odRw;
    s_wrRd(OD_OFFSET_ADDR) |=> regRdData == $past(regWrData, 3);
  endproperty
  property p_spRw;
    s_wrRd(SP_OFFSET_ADDR) |=> regRdData == $past(regWrData, 3);
  endproperty
  property p_snRw;
    s_wrRd(SN_OFFSET_ADDR) |=> regRdData == $past(regWrData, 3);
  endproperty
  property p_trigRsv;
    s_rd(TRIG_ADDR) |=> regRdData[7:1] == 7'h00;
  endproperty
  property p_calCause;
    calStart |-> $past(ce && regWrEn && regAddr == TRIG_ADDR
                       && regWrData[TRIG_BIT] && modeSel == MODE_CAL);
  endproperty
  property p_diagCause;
    diagStart |-> $past(ce && regWrEn && regAddr == TRIG_ADDR
                        && regWrData[TRIG_BIT] && modeSel == MODE_DIAG);
  endproperty
  property p_startPulse;
    calStart || diagStart |=> !calStart && !diagStart;
  endproperty
  property p_startNoDrive;
    calStart || diagStart |-> !driveOn;
  endproperty
  property p_abort;
    driveOn && ce && regWrEn && regAddr == TRIG_ADDR
      && !regWrData[TRIG_BIT] |=> !driveOn;
  endproperty
  // Most checks tie an output to the host access that caused it; two only bound the start pulses.
  a_odRw: assert property (p_odRw)
    else $error("overdrive readback");
  a_spRw: assert property (p_spRw)
    else $error("pos sustain readback");
  a_snRw: assert property (p_snRw)
    else $error("neg sustain readback");
  a_trigRsv: assert property (p_trigRsv)
    else $error("trigger upper bits");
  a_calCause: assert property (p_calCause)
    else $error("stray cal start");
  a_diagCause: assert property (p_diagCause)
    else $error("stray diag");
  a_startPulse: assert property (p_startPulse)
    else $error("long start");
  a_startNoDrive: assert property (p_startNoDrive)
    else $error("drive");
  a_abort: assert property (p_abort)
    else $error("abort too slow");
endmodule
bind hpt_trigger hpt_trigger_chk #(.STEP_CYCLES(STEP_CYCLES)) chk (
  .clk(clk), .sys_rst(sys_rst), .ce(ce), .regAddr(regAddr),
  .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regRdData(regRdData), .modeSel(modeSel), .calStart(calStart),
  .diagStart(diagStart), .driveOn(driveOn));

// file: sim/hpt_routine_model.sv
// Behavioural model of the calibration and diagnostic routines.
`timescale 1ns/1ps
module hpt_routine_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       calStart,
  input  wire logic       diagStart,
  input  wire logic [7:0] delay,
  output logic            calDone,
  output logic            diagDone
);
  int   cnt;
  logic isCal;
  // A start arms a countdown; the matching done pulses once at its end.
  always @(posedge clk) begin
    calDone <= 1'b0;
    diagDone <= 1'b0;
    if (rst) begin
      cnt <= 0;
      isCal <= 1'b0;
    end else if (calStart || diagStart) begin
      cnt <= int'(delay);
      isCal <= calStart;
    end else if (cnt == 1) begin
      cnt <= 0;
      calDone <= isCal;
      diagDone <= !isCal;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// file: sim/hpt_trigger_tb.sv
// Self-checking bench for the trigger register bank.
`timescale 1ns/1ps
module hpt_trigger_tb
  import hpt_pkg::*;
;
  localparam int SC = 4;
  logic       clk, sysRst, ce, regWrEn, regRdEn, openLoop, rdTaken;
  logic       calDone, diagDone, calStart, diagStart, driveOn;
  logic [7:0] regAddr, regWrData, regRdData, driveLevel, dly, v, runLvl;
  logic [2:0] modeSel;
  logic [7:0] rdQ[$];
  logic [7:0] lvQ[$];
  int         lnQ[$];
  int         fails = 0, checksDone = 0, runLen = 0, calCnt = 0;

  hpt_trigger #(.STEP_CYCLES(SC)) uut (
    .clk(clk), .sys_rst(sysRst), .ce(ce), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .modeSel(modeSel), .openLoop(openLoop),
    .calDone(calDone), .diagDone(diagDone), .calStart(calStart),
    .diagStart(diagStart), .driveLevel(driveLevel), .driveOn(driveOn));
  hpt_routine_model partner (
    .clk(clk), .rst(sysRst), .calStart(calStart), .diagStart(diagStart),
    .delay(dly), .calDone(calDone), .diagDone(diagDone));

  // Free-running 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic err(string m);
    fails++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic cmpRd(logic [7:0] g, logic [7:0] e);
    checksDone++;
    if (g !== e) err($sformatf("read %h exp %h", g, e));
  endtask
  task automatic cmpSeg(logic [7:0] g, int n, logic [7:0] e, int en);
    checksDone++;
    if (g !== e || (en > 0 && n != en)) err($sformatf("seg %h/%0d", g, n));
  endtask
  task automatic cmpBit(logic g, logic e);
    checksDone++;
    if (g !== e) err("status bit");
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e, bit chk);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    if (chk) rdQ.push_back(e);
    @(negedge clk);
    regRdEn = 1'b0;
  endtask
  // Polls the trigger bit; a bounded count keeps a stuck engine visible.
  task automatic waitGo(int n);
    int i;
    for (i = 0; i < n; i++) begin
      rd(TRIG_ADDR, 8'h00, 1'b0);
      if (regRdData[TRIG_BIT] === 1'b0) break;
    end
    if (i == n) err("trigger stuck");
  endtask
  task automatic seg(logic [7:0] l, int n);
    lvQ.push_back(l);
    lnQ.push_back(n);
  endtask
  // Library waveform: overdrive, positive sustain, negative sustain.
  task automatic wave(int id, int od, int sp, int sn);
    if (4 + od > 0) seg(8'h7F, (4 + od) * SC);
    if (id + sp > 0) seg(8'h40, (id + sp) * SC);
    if (2 + sn > 0) seg(8'hC0, (2 + sn) * SC);
  endtask
  task automatic offs(logic [7:0] od, logic [7:0] sp, logic [7:0] sn);
    wr(OD_OFFSET_ADDR, od);
    wr(SP_OFFSET_ADDR, sp);
    wr(SN_OFFSET_ADDR, sn);
  endtask
  task automatic go(int n);
    wr(TRIG_ADDR, 8'h01);
    rd(TRIG_ADDR, 8'h01, 1'b1);
    waitGo(n);
    rd(TRIG_ADDR, 8'h00, 1'b1);
  endtask
  task automatic testDone();
    $display("checks %0d fails %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Result watcher: each read or finished segment takes the oldest note.
  always @(posedge clk) rdTaken <= regRdEn & ce;
  always @(posedge clk) if (calStart === 1'b1 || diagStart === 1'b1) calCnt++;
  always @(negedge clk) begin
    if (rdTaken === 1'b1 && rdQ.size() != 0) begin
      cmpRd(regRdData, rdQ.pop_front());
    end
    if (driveOn === 1'b1) begin
      runLen++;
      runLvl = driveLevel;
    end else if (runLen > 0) begin
      if (lvQ.size() == 0) err("extra segment");
      else cmpSeg(runLvl, runLen, lvQ.pop_front(), lnQ.pop_front());
      runLen = 0;
    end
  end

  // Main sequence.
  initial begin
    sysRst = 1'b1;
    ce = 1'b1;
    {regWrEn, regRdEn, rdTaken, openLoop} = 4'h1;
    {regAddr, regWrData, modeSel, dly} = 27'h000_0002;
    v = $urandom(93525);
    repeat (10) @(negedge clk);
    sysRst = 1'b0;
    for (int a = 4; a < 16; a++) rd(8'(a), REG_RESET, 1'b1);
    rd(8'h2A, 8'h00, 1'b1);
    wr(TRIG_ADDR, 8'hFE);
    rd(TRIG_ADDR, 8'h00, 1'b1);
    for (int a = 13; a < 16; a++) begin
      v = 8'($urandom);
      wr(8'(a), v);
      rd(8'(a), v, 1'b1);
    end
    $display("registers done");
    modeSel = 3'($urandom_range(5));
    wr(SLOT_FIRST_ADDR, 8'h03);
    wr(8'h05, 8'h00);
    offs(8'h01, 8'hFF, 8'h02);
    wave(3, 1, -1, 2);
    go(60);
    openLoop = 1'b0;
    wave(3, 0, -1, 2);
    go(60);
    openLoop = 1'b1;
    offs(8'h01, 8'hFB, 8'hFE);
    wave(3, 1, -5, -2);
    go(60);
    $display("offsets done");
    offs(8'h00, 8'h00, 8'h00);
    for (int s = 4; s < 12; s++) begin
      wr(8'(s), 8'h01);
      wave(1, 0, 0, 0);
    end
    go(600);
    wr(SLOT_FIRST_ADDR, 8'h82);
    wr(8'h06, 8'h00);
    wave(1, 0, 0, 0);
    wr(TRIG_ADDR, 8'h01);
    repeat (2 * WAIT_STEPS * SC - 2) @(negedge clk);
    cmpBit(driveOn, 1'b0);
    waitGo(100);
    $display("sequence done");
    wr(SLOT_FIRST_ADDR, 8'h0F);
    wr(8'h05, 8'h0F);
    seg(8'h7F, 0);
    wr(TRIG_ADDR, 8'h01);
    wait (driveOn === 1'b1);
    wr(TRIG_ADDR, 8'h00);
    rd(TRIG_ADDR, 8'h00, 1'b1);
    repeat (50) @(negedge clk);
    cmpBit(driveOn, 1'b0);
    $display("abort done");
    for (int k = 0; k < 4; k++) begin
      modeSel = k[1] ? MODE_DIAG : MODE_CAL;
      dly = k[0] ? 8'($urandom_range(40, 25)) : 8'h02;
      wr(TRIG_ADDR, 8'h01);
      rd(TRIG_ADDR, 8'h01, 1'b1);
      if (k[0]) wr(TRIG_ADDR, 8'h00);
      if (k[0]) rd(TRIG_ADDR, 8'h01, 1'b1);
      waitGo(40);
    end
    cmpBit(calCnt == 4, 1'b1);
    cmpBit(lvQ.size() == 0, 1'b1);
    $display("routines done");
    testDone();
  end

  // Watchdog well beyond the thousand or so cycles the tests need.
  initial begin
    #500000;
    err("timeout");
    testDone();
  end
endmodule
